// ==== hw/alcode_pkg.sv ====
package alcode_pkg;
    // alarm number and warning range, as shown on the display
    localparam logic [7:0] WARN_LO = 8'h92;
    localparam logic [7:0] WARN_HI = 8'hEA;
    localparam logic [7:0] NO_ALARM = 8'h00;
    // digit of the configuration word that enables code output
    localparam int CFG_CODE_BIT = 0;
    // clear-method mask bits
    localparam int CLR_POWER = 0;
    localparam int CLR_KEY = 1;
    localparam int CLR_INPUT = 2;
    // sticky status bits
    localparam int ST_ALARM = 0;
    localparam int ST_WARN = 1;
    localparam int ST_CLEAR = 2;
    // register byte addresses
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_MASK = 8'h04;
    localparam logic [7:0] OFS_CFG = 8'h08;
    localparam logic [7:0] OFS_DISPLAY = 8'h0C;
    localparam logic [7:0] OFS_FAULT = 8'h10;
    localparam logic [2:0] MASK_RESET = 3'h0;
    localparam logic [2:0] CFG_RESET = 3'h0;
    typedef enum logic [0:0] {
        ALC_RUN = 1'b0,
        ALC_TRIP = 1'b1
    } alc_state_e;
endpackage : alcode_pkg

// ==== hw/alcode_if.sv ====
`timescale 1ns/1ns
interface alcode_if;
    logic [7:0] number;
    logic [2:0] code;
    logic [2:0] clear_ok;
    logic valid;
    modport src (output number, output code, output clear_ok, output valid);
    modport dst (input number, input code, input clear_ok, input valid);
endinterface : alcode_if

// ==== hw/alcode_latch.sv ====
`timescale 1ns/1ns
module alcode_latch (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, low
    input wire logic fault_valid, // fault reported this cycle
    input wire logic [7:0] fault_number, // its display number
    input wire logic [2:0] fault_code, // its output code
    input wire logic [2:0] fault_clear_ok, // allowed clear methods
    input wire logic clear_key, // set key on alarm screen
    input wire logic clear_input, // alarm clear input
    input wire logic clear_power, // power cycle
    alcode_if.src held // latched alarm
);
    logic [7:0] number, next_number;
    logic [2:0] code, next_code, okm, next_okm;
    logic valid, next_valid;
    logic clr;
    always_comb
    begin
        clr = valid && ((clear_power && okm[alcode_pkg::CLR_POWER])
            || (clear_key && okm[alcode_pkg::CLR_KEY])
            || (clear_input && okm[alcode_pkg::CLR_INPUT]));
        next_number = number;
        next_code = code;
        next_okm = okm;
        next_valid = valid;
        if (clr)
        begin
            next_valid = 1'b0;
            next_number = alcode_pkg::NO_ALARM;
        end
        // first alarm latched; new alarm beats clear
        if (fault_valid && (!valid || clr))
        begin
            next_valid = 1'b1;
            next_number = fault_number;
            next_code = fault_code;
            next_okm = fault_clear_ok;
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            number <= 8'h00;
            code <= 3'h0;
            okm <= 3'h0;
            valid <= 1'b0;
        end
        else
        begin
            number <= next_number;
            code <= next_code;
            okm <= next_okm;
            valid <= next_valid;
        end
    end
    assign held.number = number;
    assign held.code = code;
    assign held.clear_ok = okm;
    assign held.valid = valid;
    held_until_a: assert property (@(posedge pclk) disable iff (!presetn)
        valid && !clr |=> valid) else $error("alarm dropped without clear");
    bad_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        valid && clear_input && !okm[alcode_pkg::CLR_INPUT] && !clear_key && !clear_power
        |=> valid) else $error("clear input cleared forbidden alarm");
endmodule : alcode_latch

// ==== hw/alcode_top.sv ====
`timescale 1ns/1ns
module alcode_top (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb write
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic fault_valid, // fault detected pulse
    input wire logic [7:0] fault_number, // fault display number
    input wire logic [2:0] fault_code, // alarm code of fault
    input wire logic [2:0] fault_clear_ok, // permitted clears
    input wire logic clear_key, // set key on alarm screen
    input wire logic alarm_clear_input, // external clear
    input wire logic clear_power, // power on clear pulse
    input wire logic zero_speed_flag, // normal pin 0
    input wire logic in_position_flag, // normal pin 1
    input wire logic ready_flag, // normal pin 2
    output logic [2:0] code_pins, // three output pins, 1 = on
    output logic trouble_output, // 1 = no alarm
    output logic dyn_brake, // dynamic brake on
    output logic [7:0] display_number, // shown number
    output logic irq // interrupt level
);
    ////////////////////////////////////////////////////////////////////
    logic is_warn;
    alcode_if held ();
    alcode_latch u_latch (
        .pclk(pclk),
        .presetn(presetn),
        .fault_valid(fault_valid && !is_warn),
        .fault_number(fault_number),
        .fault_code(fault_code),
        .fault_clear_ok(fault_clear_ok),
        .clear_key(clear_key),
        .clear_input(alarm_clear_input),
        .clear_power(clear_power),
        .held(held.src)
    );

    function automatic logic warn_range(input logic [7:0] n);
        warn_range = (n >= alcode_pkg::WARN_LO) && (n <= alcode_pkg::WARN_HI);
    endfunction : warn_range

    assign is_warn = warn_range(fault_number);

    ////////////////////////////////////////////////////////////////////
    logic [2:0] status, next_status, mask, next_mask, cfg, next_cfg;
    logic [7:0] warn_number, next_warn_number;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr, acc, rd;
    alcode_pkg::alc_state_e state, next_state;
    logic [2:0] next_code_pins;
    logic next_trouble, next_brake, next_irq;
    logic [7:0] next_display;

    always_comb
    begin
        acc = psel && penable && !pready;
        rd = acc && !pwrite;
        next_mask = mask;
        next_cfg = cfg;
        next_prdata = 32'h0000_0000;
        next_pslverr = 1'b0;
        next_pready = acc;
        next_status = status;
        if (rd && paddr == alcode_pkg::OFS_STATUS)
        begin
            next_status = 3'h0;
            next_prdata = {29'h0, status};
        end
        else if (paddr == alcode_pkg::OFS_MASK)
        begin
            next_prdata = {29'h0, mask};
            if (acc && pwrite)
                next_mask = pwdata[2:0];
        end
        else if (paddr == alcode_pkg::OFS_CFG)
        begin
            next_prdata = {29'h0, cfg};
            if (acc && pwrite)
                next_cfg = pwdata[2:0];
        end
        else if (paddr == alcode_pkg::OFS_DISPLAY)
            next_prdata = {24'h0, display_number};
        else if (paddr == alcode_pkg::OFS_FAULT)
            next_prdata = {20'h0, held.clear_ok, held.code, 5'h0, state};
        else
            next_pslverr = acc;
        if (!acc)
            next_prdata = 32'h0000_0000;
        // set beats read clear
        if (fault_valid && !is_warn)
            next_status[alcode_pkg::ST_ALARM] = 1'b1;
        if (fault_valid && is_warn)
            next_status[alcode_pkg::ST_WARN] = 1'b1;
        if (state == alcode_pkg::ALC_TRIP && !held.valid)
            next_status[alcode_pkg::ST_CLEAR] = 1'b1;
        next_irq = |(next_status & mask);

        // warnings clear themselves when the cause goes; shown until then
        next_warn_number = warn_number;
        if (fault_valid && is_warn)
            next_warn_number = fault_number;
        else if (!fault_valid)
            next_warn_number = alcode_pkg::NO_ALARM;

        next_state = held.valid ? alcode_pkg::ALC_TRIP : alcode_pkg::ALC_RUN;
        next_trouble = !held.valid;
        next_brake = held.valid;
        next_display = held.valid ? held.number : next_warn_number;
        if (held.valid && cfg[alcode_pkg::CFG_CODE_BIT])
            next_code_pins = held.code;
        else
            next_code_pins = {ready_flag, in_position_flag, zero_speed_flag};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status <= 3'h0;
            mask <= alcode_pkg::MASK_RESET;
            cfg <= alcode_pkg::CFG_RESET;
            warn_number <= 8'h00;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            state <= alcode_pkg::ALC_RUN;
            code_pins <= 3'h0;
            trouble_output <= 1'b0;
            dyn_brake <= 1'b0;
            display_number <= 8'h00;
            irq <= 1'b0;
        end
        else
        begin
            status <= next_status;
            mask <= next_mask;
            cfg <= next_cfg;
            warn_number <= next_warn_number;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            state <= next_state;
            code_pins <= next_code_pins;
            trouble_output <= next_trouble;
            dyn_brake <= next_brake;
            display_number <= next_display;
            irq <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // warning gives no code
    warn_nocode_a: assert property (@(posedge pclk) disable iff (!presetn)
        fault_valid && is_warn && !held.valid |=> !dyn_brake
        && code_pins == $past({ready_flag, in_position_flag, zero_speed_flag})) else $error("warn tripped");
    code_out_a: assert property (@(posedge pclk) disable iff (!presetn)
        held.valid && cfg[0] |=> code_pins == $past(held.code)) else $error("code missing");
    code_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
        !held.valid || !cfg[alcode_pkg::CFG_CODE_BIT]
        |=> code_pins == $past({ready_flag, in_position_flag, zero_speed_flag})) else $error("code without alarm");
    normal_pins_a: assert property (@(posedge pclk) disable iff (!presetn)
        !held.valid |=> code_pins == $past({ready_flag, in_position_flag, zero_speed_flag}))
        else $error("normal pins wrong");
    show_num_a: assert property (@(posedge pclk) disable iff (!presetn)
        held.valid |=> display_number == $past(held.number)) else $error("display wrong");
    trouble_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        fault_valid && !is_warn |=> ##1 !trouble_output && dyn_brake)
        else $error("trouble not dropped");
    clear_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(held.valid) |-> $past(clear_key || alarm_clear_input || clear_power))
        else $error("spontaneous clear");
    latch_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        held.valid && !clear_key && !alarm_clear_input && !clear_power |=> held.valid)
        else $error("latch lost");
    apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready |=> pready) else $error("apb late");
    alarm_c: cover property (@(posedge pclk) disable iff (!presetn)
        fault_valid && !is_warn ##[1:20] !held.valid);
    warn_c: cover property (@(posedge pclk) disable iff (!presetn) fault_valid && is_warn);
    coded_c: cover property (@(posedge pclk) disable iff (!presetn) held.valid && cfg[0]);
    // interrupt follows masked status on the same edge, using the mask of one edge before
    irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        irq == |(status & $past(mask))) else $error("irq level wrong");
    // events land in status even during a read clear
    alarm_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        fault_valid && !is_warn |=> status[alcode_pkg::ST_ALARM])
        else $error("alarm not flagged");
    warn_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        fault_valid && is_warn |=> status[alcode_pkg::ST_WARN])
        else $error("warning not flagged");
    apb_error_a: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready) else $error("error without ready");
    clear_c: cover property (@(posedge pclk) disable iff (!presetn) $fell(held.valid));
    refuse_c: cover property (@(posedge pclk) disable iff (!presetn)
        held.valid && alarm_clear_input && !held.clear_ok[alcode_pkg::CLR_INPUT]);
endmodule : alcode_top

// ==== sim/alcode_ctrl_model.sv ====
`timescale 1ns/1ns
module alcode_ctrl_model (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, low
    input wire logic trouble_output, // 1 = healthy
    input wire logic clear_req, // bench asks for a clear
    output logic servo_enable_input, // servo on request
    output logic alarm_clear_input // clear pulse to device
);
    ////////////////////////////////////////////////////////////////
    // servo off on alarm
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            servo_enable_input <= 1'b0;
            alarm_clear_input <= 1'b0;
        end
        else
        begin
            servo_enable_input <= trouble_output;
            alarm_clear_input <= clear_req;
        end
    end
endmodule : alcode_ctrl_model

// ==== sim/alcode_top_tb.sv ====
`timescale 1ns/1ns
module alcode_top_tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, fault_number = 8'h00, display_number, n;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, fault_valid = 1'b0, clear_key = 1'b0, clear_power = 1'b0;
    logic clear_req = 1'b0, alarm_clear_input, trouble_output, dyn_brake, irq, er, cfg;
    logic servo_enable_input;
    logic [2:0] fault_code = 3'h0, fault_clear_ok = 3'h0, flags = 3'h0, code_pins, c, ok;
    logic [7:0] warn [4] = '{8'h92, 8'h96, 8'hE0, 8'hEA};
    int fails = 0;
    int n_checks = 0;
    int k, m;
    always #5 pclk = ~pclk;
    alcode_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .fault_valid, .fault_number, .fault_code, .fault_clear_ok,
        .clear_key, .alarm_clear_input, .clear_power, .zero_speed_flag(flags[0]),
        .in_position_flag(flags[1]), .ready_flag(flags[2]), .code_pins, .trouble_output,
        .dyn_brake, .display_number, .irq);
    alcode_ctrl_model ctrl (.pclk, .presetn, .trouble_output, .clear_req,
        .servo_enable_input, .alarm_clear_input);
    ////////////////////////////////////////////////////////////////
    task results;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task tick(input int t);
        repeat (t) @(posedge pclk);
    endtask : tick
    // one fixed setup cycle, then waits on pready, giving up after 20 cycles
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20 && pready !== 1'b1; i++)
            @(posedge pclk);
        if (i == 20)
        begin
            fails++;
            results;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task pulse(input int sel);
        clear_power <= (sel == 0);
        clear_key <= (sel == 1);
        clear_req <= (sel == 2);
        tick(1);
        {clear_req, clear_key, clear_power} <= 3'h0;
        tick(5);
    endtask : pulse
    function logic [2:0] exp_pins(input logic en, input logic [2:0] cd, input logic [2:0] f);
        return en ? cd : f;
    endfunction : exp_pins
    ////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(32'hF4E92D96));
        tick(5);
        presetn <= 1'b1;
        tick(2);
        chk("trouble", 1, trouble_output);
        apb(0, alcode_pkg::OFS_MASK, 0);
        chk("mask", 0, rd);
        apb(0, 8'h20, 0);
        chk("unmapped", 1, er);
        chk("unmapped data", 0, rd);
        apb(1, alcode_pkg::OFS_MASK, 32'h7);
        apb(1, alcode_pkg::OFS_CFG, 32'h1);
        $display("test reset done");
        for (k = 0; k < 4; k++)
        begin
            flags <= 3'($urandom);
            fault_number <= warn[k];
            fault_code <= 3'($urandom);
            fault_valid <= 1'b1;
            tick(5);
            chk("warn display", warn[k], display_number);
            chk("warn pins", flags, code_pins);
            chk("warn trouble", 1, trouble_output);
            fault_valid <= 1'b0;
            apb(0, alcode_pkg::OFS_STATUS, 0);
            chk("warn status", 2, rd);
        end
        $display("test warnings done");
        for (k = 0; k < 6; k++)
        begin
            cfg = 1'($urandom);
            apb(1, alcode_pkg::OFS_CFG, {31'h0, cfg});
            n = 8'($urandom_range(2, 8'h91));
            c = 3'($urandom);
            ok = 3'($urandom_range(1, 7));
            flags <= 3'($urandom);
            {fault_number, fault_code, fault_clear_ok, fault_valid} <= {n, c, ok, 1'b1};
            tick(1);
            fault_valid <= 1'b0;
            tick(5);
            chk("trouble", 0, trouble_output);
            chk("brake", 1, dyn_brake);
            chk("display", n, display_number);
            chk("pins", exp_pins(cfg, c, flags), code_pins);
            chk("irq", 1, irq);
            chk("servo", 0, servo_enable_input);
            apb(0, alcode_pkg::OFS_FAULT, 0);
            chk("fault reg", {20'h0, ok, c, 5'h00, 1'b1}, rd);
            apb(0, alcode_pkg::OFS_DISPLAY, 0);
            chk("display reg", {24'h0, n}, rd);
            apb(0, alcode_pkg::OFS_STATUS, 0);
            chk("status", 1, rd);
            {fault_number, fault_valid} <= {n ^ 8'h01, 1'b1};
            tick(1);
            fault_valid <= 1'b0;
            tick(5);
            chk("held display", n, display_number);
            for (m = 0; m < 3; m++)
                if (!ok[m])
                begin
                    pulse(m);
                    chk("refused clear", 0, trouble_output);
                end
            for (m = 0; !ok[m]; m++);
            pulse(m);
            chk("cleared", 1, trouble_output);
            chk("brake off", 0, dyn_brake);
            chk("idle pins", flags, code_pins);
            chk("idle display", alcode_pkg::NO_ALARM, display_number);
            apb(0, alcode_pkg::OFS_STATUS, 0);
            chk("clr status", 5, rd);
            tick(3);
            chk("irq low", 0, irq);
        end
        $display("test alarms done");
        results;
    end
endmodule : alcode_top_tb
